/* File: sipr_host.sv */
`timescale 1ns/10ps
// ****
// bus master model, clock driven directly, data open drain
// ****
module sipr_host (
   input  wire logic clk_sys_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      pull_o
);
   // idle bus: clock high, data released
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   // wait n falling edges of the system clock
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // start, or repeated start when the clock is low
   task automatic start();
      wt(2);
      pull_o = 1'b0;
      wt(8);
      scl_o = 1'b1;
      wt(10);
      pull_o = 1'b1;
      wt(10);
      scl_o = 1'b0;
   endtask
   // data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      wt(2);
      pull_o = !b;
      wt(8);
      scl_o = 1'b1;
      wt(10);
      s = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic stop();
      wt(2);
      pull_o = 1'b1;
      wt(8);
      scl_o = 1'b1;
      wt(10);
      pull_o = 1'b0;
      wt(10);
   endtask
   // msb first, then the target's acknowledge
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   // last byte is refused so the target lets go of the line
   task automatic byte_r(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask
endmodule

/* File: sipr_pkg.sv */
package sipr_pkg;

   // ****************************************
   // bus target address and command byte
   // ****************************************
   localparam logic [6:0] TARGET_ADDR    = 7'h39;
   localparam int         CMD_SEL_BIT    = 7;
   localparam int         CMD_TYPE_MSB   = 6;
   localparam int         CMD_TYPE_LSB   = 5;
   localparam logic [1:0] TYPE_REPEAT    = 2'h0;
   localparam logic [1:0] TYPE_AUTOINC   = 2'h1;
   localparam logic [1:0] TYPE_SPECIAL   = 2'h3;
   localparam logic [4:0] SPF_NONE       = 5'h00;
   localparam logic [4:0] SPF_CLR_PROX   = 5'h05;
   localparam logic [4:0] SPF_CLR_LIGHT  = 5'h06;
   localparam logic [4:0] SPF_CLR_BOTH   = 5'h07;
   localparam logic [7:0] CMD_RESET      = 8'h00;
   localparam logic [3:0] BYTE_BITS      = 4'h8;

   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [4:0] A_FUNC_EN      = 5'h00;
   localparam logic [4:0] A_LIGHT_ITIME  = 5'h01;
   localparam logic [4:0] A_PROX_ITIME   = 5'h02;
   localparam logic [4:0] A_WAIT_TIME    = 5'h03;
   localparam logic [4:0] A_LLT_LO       = 5'h04;
   localparam logic [4:0] A_LLT_HI       = 5'h05;
   localparam logic [4:0] A_LHT_LO       = 5'h06;
   localparam logic [4:0] A_LHT_HI       = 5'h07;
   localparam logic [4:0] A_PLT_LO       = 5'h08;
   localparam logic [4:0] A_PLT_HI       = 5'h09;
   localparam logic [4:0] A_PHT_LO       = 5'h0a;
   localparam logic [4:0] A_PHT_HI       = 5'h0b;
   localparam logic [4:0] A_PERSIST      = 5'h0c;
   localparam logic [4:0] A_CONFIG       = 5'h0d;
   localparam logic [4:0] A_PULSE        = 5'h0e;
   localparam logic [4:0] A_GAIN         = 5'h0f;
   localparam logic [4:0] A_IDENT        = 5'h12;
   localparam logic [4:0] A_STATUS       = 5'h13;
   localparam logic [4:0] A_CH0_LO       = 5'h14;
   localparam logic [4:0] A_CH0_HI       = 5'h15;
   localparam logic [4:0] A_CH1_LO       = 5'h16;
   localparam logic [4:0] A_CH1_HI       = 5'h17;
   localparam logic [4:0] A_PRX_LO       = 5'h18;
   localparam logic [4:0] A_PRX_HI       = 5'h19;
   localparam logic [4:0] A_OFFSET       = 5'h1e;

   // ****************************************
   // reset values and field positions
   // ****************************************
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_TIME       = 8'hff;
   localparam logic [7:0] FUNC_EN_MASK   = 8'h7f;
   localparam int         POWER_ON_BIT   = 0;
   localparam int         LIGHT_EN_BIT   = 1;
   localparam int         PROX_EN_BIT    = 2;
   localparam int         WAIT_EN_BIT    = 3;
   localparam int         LIGHT_IRQ_BIT  = 4;
   localparam int         PROX_IRQ_BIT   = 5;
   localparam int         SLEEP_IRQ_BIT  = 6;
   localparam int         LONG_WAIT_BIT  = 1;
   localparam logic [3:0] LONG_WAIT_MUL  = 4'hc;
   localparam logic [8:0] WAIT_STEPS     = 9'h100;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_AACK   = 3'b010,
      ST_WBYTE  = 3'b011,
      ST_WACK   = 3'b100,
      ST_RBYTE  = 3'b101,
      ST_RACK   = 3'b110
   } sipr_state_t;

   typedef struct packed {
      logic [7:0]  func_en;
      logic [7:0]  light_itime;
      logic [7:0]  prox_itime;
      logic [7:0]  wait_time;
      logic [15:0] light_lo_th;
      logic [15:0] light_hi_th;
      logic [15:0] prox_lo_th;
      logic [15:0] prox_hi_th;
      logic [7:0]  persist;
      logic [7:0]  config_bits;
      logic [7:0]  pulse_count;
      logic [7:0]  gain;
      logic [7:0]  offset;
   } sipr_cfg_t;

   typedef struct packed {
      logic [7:0]  status;
      logic [15:0] chan0;
      logic [15:0] chan1;
      logic [15:0] prox;
   } sipr_meas_t;

   localparam sipr_cfg_t CFG_RESET = '{
      func_en: RST_ZERO, light_itime: RST_TIME, prox_itime: RST_TIME,
      wait_time: RST_TIME, light_lo_th: 16'h0000, light_hi_th: 16'h0000,
      prox_lo_th: 16'h0000, prox_hi_th: 16'h0000, persist: RST_ZERO,
      config_bits: RST_ZERO, pulse_count: RST_ZERO, gain: RST_ZERO,
      offset: RST_ZERO};

endpackage

/* File: sipr_target.sv */
`timescale 1ns/10ps
module sipr_target #(
   parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary identity value
) (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe_o,
   input  wire sipr_pkg::sipr_meas_t meas_i,
   output sipr_pkg::sipr_cfg_t      cfg_o,
   output logic [11:0]              wait_span_o,
   output logic                     prox_irq_clr_o,
   output logic                     light_irq_clr_o
);

   // ****************************************
   // register access functions
   // ****************************************
   function automatic logic [7:0] rd_reg(input sipr_pkg::sipr_cfg_t c,
                                         input sipr_pkg::sipr_meas_t m,
                                         input logic [4:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         sipr_pkg::A_FUNC_EN:     d = c.func_en;
         sipr_pkg::A_LIGHT_ITIME: d = c.light_itime;
         sipr_pkg::A_PROX_ITIME:  d = c.prox_itime;
         sipr_pkg::A_WAIT_TIME:   d = c.wait_time;
         sipr_pkg::A_LLT_LO:      d = c.light_lo_th[7:0];
         sipr_pkg::A_LLT_HI:      d = c.light_lo_th[15:8];
         sipr_pkg::A_LHT_LO:      d = c.light_hi_th[7:0];
         sipr_pkg::A_LHT_HI:      d = c.light_hi_th[15:8];
         sipr_pkg::A_PLT_LO:      d = c.prox_lo_th[7:0];
         sipr_pkg::A_PLT_HI:      d = c.prox_lo_th[15:8];
         sipr_pkg::A_PHT_LO:      d = c.prox_hi_th[7:0];
         sipr_pkg::A_PHT_HI:      d = c.prox_hi_th[15:8];
         sipr_pkg::A_PERSIST:     d = c.persist;
         sipr_pkg::A_CONFIG:      d = c.config_bits;
         sipr_pkg::A_PULSE:       d = c.pulse_count;
         sipr_pkg::A_GAIN:        d = c.gain;
         sipr_pkg::A_IDENT:       d = DEVICE_ID;
         sipr_pkg::A_STATUS:      d = m.status;
         sipr_pkg::A_CH0_LO:      d = m.chan0[7:0];
         sipr_pkg::A_CH0_HI:      d = m.chan0[15:8];
         sipr_pkg::A_CH1_LO:      d = m.chan1[7:0];
         sipr_pkg::A_CH1_HI:      d = m.chan1[15:8];
         sipr_pkg::A_PRX_LO:      d = m.prox[7:0];
         sipr_pkg::A_PRX_HI:      d = m.prox[15:8];
         sipr_pkg::A_OFFSET:      d = c.offset;
         default:                 d = 8'h00;
      endcase
      return d;
   endfunction

   function automatic sipr_pkg::sipr_cfg_t wr_reg(
      input sipr_pkg::sipr_cfg_t c, input logic [4:0] a,
      input logic [7:0] d);
      sipr_pkg::sipr_cfg_t r;
      r = c;
      case (a)
         sipr_pkg::A_FUNC_EN:     r.func_en = d & sipr_pkg::FUNC_EN_MASK;
         sipr_pkg::A_LIGHT_ITIME: r.light_itime = d;
         sipr_pkg::A_PROX_ITIME:  r.prox_itime = d;
         sipr_pkg::A_WAIT_TIME:   r.wait_time = d;
         sipr_pkg::A_LLT_LO:      r.light_lo_th[7:0] = d;
         sipr_pkg::A_LLT_HI:      r.light_lo_th[15:8] = d;
         sipr_pkg::A_LHT_LO:      r.light_hi_th[7:0] = d;
         sipr_pkg::A_LHT_HI:      r.light_hi_th[15:8] = d;
         sipr_pkg::A_PLT_LO:      r.prox_lo_th[7:0] = d;
         sipr_pkg::A_PLT_HI:      r.prox_lo_th[15:8] = d;
         sipr_pkg::A_PHT_LO:      r.prox_hi_th[7:0] = d;
         sipr_pkg::A_PHT_HI:      r.prox_hi_th[15:8] = d;
         sipr_pkg::A_PERSIST:     r.persist = d;
         sipr_pkg::A_CONFIG:      r.config_bits = d;
         sipr_pkg::A_PULSE:       r.pulse_count = d;
         sipr_pkg::A_GAIN:        r.gain = d;
         sipr_pkg::A_OFFSET:      r.offset = d;
         default:                 r = c;
      endcase
      return r;
   endfunction

   // next address: only the auto-increment type moves the pointer
   function automatic logic [4:0] adv(input logic [4:0] p,
                                      input logic [1:0] t);
      return (t == sipr_pkg::TYPE_AUTOINC) ? 5'(p + 5'h01) : p;
   endfunction

   // ****************************************
   // pin synchronisers and bus events
   // ****************************************
   logic [2:0] scl_sync_r;
   logic [2:0] sda_sync_r;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;

   // two stages per pin, then one history stage for edge detection
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
      end else begin
         scl_sync_r <= {scl_sync_r[1:0], scl_i};
         sda_sync_r <= {sda_sync_r[1:0], sda_i};
      end
   end

   // oversampled edges cover standard and fast mode clocks
   assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
   assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
   assign bus_start = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] &
                      ~sda_sync_r[1];
   assign bus_stop  = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] &
                      sda_sync_r[1];

   // ****************************************
   // protocol engine
   // ****************************************
   sipr_pkg::sipr_state_t st_r, st_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [7:0]  rx_r, rx_nxt;
   logic [7:0]  tx_r, tx_nxt;
   logic        first_r, first_nxt;
   logic        rnw_r, rnw_nxt;
   logic        nack_r, nack_nxt;
   logic [4:0]  ptr_r, ptr_nxt;
   logic [1:0]  type_r, type_nxt;
   logic [7:0]  cmd_r, cmd_nxt;
   logic        oe_r, oe_nxt;
   logic        pclr_r, pclr_nxt;
   logic        lclr_r, lclr_nxt;
   logic [11:0] wspan_r, wspan_nxt;
   sipr_pkg::sipr_cfg_t cfg_r, cfg_nxt;
   logic        wr_end;
   logic [7:0]  rd_data;

   assign wr_end = scl_fall && st_r == sipr_pkg::ST_WBYTE &&
                   cnt_r == sipr_pkg::BYTE_BITS;
   // next state of bus engine, pointer and register file
   always_comb begin
      logic [4:0] np;
      logic [7:0] cur;
      np        = adv(ptr_r, type_r);
      cur       = rd_reg(cfg_r, meas_i, ptr_r);
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      rx_nxt    = rx_r;
      tx_nxt    = tx_r;
      first_nxt = first_r;
      rnw_nxt   = rnw_r;
      nack_nxt  = nack_r;
      ptr_nxt   = ptr_r;
      type_nxt  = type_r;
      cmd_nxt   = cmd_r;
      oe_nxt    = oe_r;
      pclr_nxt  = 1'b0;
      lclr_nxt  = 1'b0;
      cfg_nxt   = cfg_r;
      rd_data   = rd_reg(cfg_r, meas_i, np);
      // long wait stretches the span twelve times
      wspan_nxt = 12'(sipr_pkg::WAIT_STEPS - {1'b0, cfg_r.wait_time});
      if (cfg_r.config_bits[sipr_pkg::LONG_WAIT_BIT]) begin
         wspan_nxt = 12'(wspan_nxt * sipr_pkg::LONG_WAIT_MUL);
      end
      if (bus_start) begin
         // start or repeated start: new address phase
         st_nxt    = sipr_pkg::ST_ADDR;
         cnt_nxt   = 4'h0;
         first_nxt = 1'b1;
         oe_nxt    = 1'b0;
      end else if (bus_stop) begin
         st_nxt = sipr_pkg::ST_IDLE;
         oe_nxt = 1'b0;
      end else if (scl_rise) begin
         if (st_r == sipr_pkg::ST_ADDR || st_r == sipr_pkg::ST_WBYTE) begin
            rx_nxt  = {rx_r[6:0], sda_sync_r[1]};
            cnt_nxt = 4'(cnt_r + 4'h1);
         end else if (st_r == sipr_pkg::ST_RBYTE) begin
            cnt_nxt = 4'(cnt_r + 4'h1);
         end else if (st_r == sipr_pkg::ST_RACK) begin
            nack_nxt = sda_sync_r[1];
         end
      end else if (scl_fall) begin
         case (st_r)
            sipr_pkg::ST_ADDR: begin
               if (cnt_r == sipr_pkg::BYTE_BITS) begin
                  if (rx_r[7:1] == sipr_pkg::TARGET_ADDR) begin
                     st_nxt  = sipr_pkg::ST_AACK;
                     rnw_nxt = rx_r[0];
                     oe_nxt  = 1'b1;
                  end else begin
                     st_nxt = sipr_pkg::ST_IDLE;
                  end
               end
            end
            sipr_pkg::ST_AACK, sipr_pkg::ST_WACK: begin
               cnt_nxt = 4'h0;
               if (rnw_r) begin
                  st_nxt = sipr_pkg::ST_RBYTE;
                  tx_nxt = {cur[6:0], 1'b0};
                  oe_nxt = ~cur[7];
               end else begin
                  st_nxt = sipr_pkg::ST_WBYTE;
                  oe_nxt = 1'b0;
               end
            end
            sipr_pkg::ST_WBYTE: begin
               if (cnt_r == sipr_pkg::BYTE_BITS) begin
                  st_nxt    = sipr_pkg::ST_WACK;
                  oe_nxt    = 1'b1;
                  first_nxt = 1'b0;
                  if (first_r && rx_r[sipr_pkg::CMD_SEL_BIT]) begin
                     cmd_nxt = rx_r;
                     if (rx_r[6:5] == sipr_pkg::TYPE_SPECIAL) begin
                        // clear pulses, pointer kept
                        pclr_nxt = rx_r[4:0] == sipr_pkg::SPF_CLR_PROX ||
                                   rx_r[4:0] == sipr_pkg::SPF_CLR_BOTH;
                        lclr_nxt = rx_r[4:0] == sipr_pkg::SPF_CLR_LIGHT ||
                                   rx_r[4:0] == sipr_pkg::SPF_CLR_BOTH;
                     end else begin
                        ptr_nxt  = rx_r[4:0];
                        type_nxt = rx_r[6:5];
                     end
                  end else begin
                     cfg_nxt = wr_reg(cfg_r, ptr_r, rx_r);
                     ptr_nxt = np;
                  end
               end
            end
            sipr_pkg::ST_RBYTE: begin
               if (cnt_r == sipr_pkg::BYTE_BITS) begin
                  st_nxt = sipr_pkg::ST_RACK;
                  oe_nxt = 1'b0;
               end else begin
                  oe_nxt = ~tx_r[7];
                  tx_nxt = {tx_r[6:0], 1'b0};
               end
            end
            sipr_pkg::ST_RACK: begin
               if (nack_r) begin
                  st_nxt = sipr_pkg::ST_IDLE;
               end else begin
                  // acked: step pointer in auto-increment type only, next byte (low then high)
                  st_nxt  = sipr_pkg::ST_RBYTE;
                  cnt_nxt = 4'h0;
                  ptr_nxt = np;
                  tx_nxt  = {rd_data[6:0], 1'b0};
                  oe_nxt  = ~rd_data[7];
               end
            end
            default: st_nxt = sipr_pkg::ST_IDLE;
         endcase
      end
   end

   // registers of the protocol engine and register file
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r    <= sipr_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
         rx_r    <= 8'h00;
         tx_r    <= 8'h00;
         first_r <= 1'b0;
         rnw_r   <= 1'b0;
         nack_r  <= 1'b0;
         ptr_r   <= sipr_pkg::CMD_RESET[4:0];
         type_r  <= sipr_pkg::CMD_RESET[6:5];
         cmd_r   <= sipr_pkg::CMD_RESET;
         oe_r    <= 1'b0;
         pclr_r  <= 1'b0;
         lclr_r  <= 1'b0;
         wspan_r <= 12'h000;
         cfg_r   <= sipr_pkg::CFG_RESET;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         rx_r    <= rx_nxt;
         tx_r    <= tx_nxt;
         first_r <= first_nxt;
         rnw_r   <= rnw_nxt;
         nack_r  <= nack_nxt;
         ptr_r   <= ptr_nxt;
         type_r  <= type_nxt;
         cmd_r   <= cmd_nxt;
         oe_r    <= oe_nxt;
         pclr_r  <= pclr_nxt;
         lclr_r  <= lclr_nxt;
         wspan_r <= wspan_nxt;
         cfg_r   <= cfg_nxt;
      end
   end

   // outputs straight from registers, sda_o tied to 0; pin only ever pulls low
   assign sda_o           = 1'b0;
   assign sda_oe_o        = oe_r;
   assign cfg_o           = cfg_r;
   assign wait_span_o     = wspan_r;
   assign prox_irq_clr_o  = pclr_r;
   assign light_irq_clr_o = lclr_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_cmd_ptr_load: assert property (
      wr_end && first_r && rx_r[7] && rx_r[6:5] != 2'h3
      |=> ptr_r == $past(rx_r[4:0]) && type_r == $past(rx_r[6:5]))
      else $error("command did not load pointer");
   a_clear_both: assert property (
      wr_end && first_r && rx_r == 8'he7
      |=> prox_irq_clr_o && light_irq_clr_o ##1
          !prox_irq_clr_o && !light_irq_clr_o)
      else $error("clear pulse wrong");
   a_clear_only: assert property (
      $rose(prox_irq_clr_o) |-> $past(wr_end) && $past(first_r) &&
      $past(rx_r[7:5]) == 3'h7)
      else $error("clear without special command");
   a_enable_write: assert property (
      wr_end && !(first_r && rx_r[7]) && ptr_r == 5'h00
      |=> cfg_o.func_en == ($past(rx_r) & 8'h7f))
      else $error("enable register not written");
   a_auto_incr: assert property (
      wr_end && !(first_r && rx_r[7]) && type_r == 2'h1
      |=> ptr_r == 5'($past(ptr_r) + 5'h01))
      else $error("pointer did not increment");
   a_repeat_hold: assert property (
      wr_end && !(first_r && rx_r[7]) && type_r == 2'h0 |=> $stable(ptr_r))
      else $error("pointer moved in repeat mode");
   a_addr_ignore: assert property (
      scl_fall && st_r == sipr_pkg::ST_ADDR && cnt_r == 4'h8 &&
      rx_r[7:1] != 7'h39 |=> st_r == sipr_pkg::ST_IDLE && !sda_oe_o)
      else $error("foreign address acknowledged");
   a_data_keep_cmd: assert property (
      wr_end && first_r && !rx_r[7] |=> $stable(cmd_r))
      else $error("data byte taken as command");
   a_unmapped_wr: assert property (
      wr_end && !(first_r && rx_r[7]) &&
      (ptr_r inside {5'h10, 5'h11, [5'h12:5'h19], [5'h1a:5'h1d], 5'h1f})
      |=> $stable(cfg_o))
      else $error("write to unmapped or read-only address");
   a_long_wait: assert property (
      cfg_o.config_bits[1] && $stable(cfg_o) ##1 $stable(cfg_o)
      |-> wait_span_o == 12'((9'h100 - {1'b0, cfg_o.wait_time}) * 4'hc))
      else $error("long wait span wrong");

endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
// ****
// register port testbench
// ****
module tb_top;
   logic                 clk_sys_i, rst_i, scl, pull, sda_oe, pc, lc, ak;
   sipr_pkg::sipr_meas_t meas;
   sipr_pkg::sipr_cfg_t  cfg;
   logic [11:0]          span;
   logic [7:0]           rb;
   logic [15:0]          w;
   logic [4:0]           rw [9] = '{5'h00, 5'h04, 5'h07, 5'h08, 5'h0b,
                                    5'h0c, 5'h0e, 5'h0f, 5'h1e};
   int                   bad_count, samples_checked, n_prox, n_light;
   wire sda = !(pull | sda_oe);  // pulled up when nobody drives
   sipr_target DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .meas_i(meas),
      .cfg_o(cfg), .wait_span_o(span), .prox_irq_clr_o(pc),
      .light_irq_clr_o(lc));
   sipr_host host (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
      .pull_o(pull));
   // clock and pulse counters
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      n_prox += int'(pc);
      n_light += int'(lc);
   end
   task automatic chk(input string nm, input logic [15:0] e, s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // start, write address, command byte
   task automatic head(input logic [7:0] c);
      host.start();
      host.byte_w(8'h72, ak);
      chk("addr ack", 16'h1, 16'(ak));
      host.byte_w(c, ak);
      chk("cmd ack", 16'h1, 16'(ak));
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      head(8'h80 | 8'(a));
      host.byte_w(d, ak);
      chk("data ack", 16'h1, 16'(ak));
      host.stop();
   endtask
   // read n bytes, first byte in the low half
   task automatic rd(input int n, output logic [15:0] v);
      v = 16'h0000;
      host.start();
      host.byte_w(8'h73, ak);
      for (int i = 0; i < n; i++) begin
         host.byte_r(rb, i == n - 1);
         v[8*i+:8] = rb;
      end
      host.stop();
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys_i);
      bad_count++;
      close_out();
   end
   // main sequence
   initial begin
      rst_i = 1'b1;
      meas = '{8'h00, 16'h1234, 16'h5678, 16'h9abc};
      repeat (16) @(negedge clk_sys_i);
      rst_i = 1'b0;
      host.wt(4);
      chk("cfg reset", 16'h1, 16'(cfg === sipr_pkg::CFG_RESET));
      host.start();
      host.byte_w(8'h74, ak);
      chk("other addr", 16'h0, 16'(ak));
      host.stop();
      head(8'h81);
      rd(1, w);
      chk("time reset", 16'h00ff, w);
      wr(5'h00, 8'h00);
      foreach (rw[i]) begin
         wr(rw[i], 8'h40 | 8'(rw[i]));
         head(8'h80 | 8'(rw[i]));
         rd(1, w);
         chk("rw reg", {8'h00, 8'h40 | 8'(rw[i])}, w);
      end
      wr(5'h14, 8'hff);
      for (int i = 0; i < 3; i++) begin
         head(8'ha0 | (8'h14 + 8'(2 * i)));
         rd(2, w);
         chk("word", meas[47-16*i-:16], w);
      end
      head(8'h84);
      rd(2, w);
      chk("repeat", 16'h4444, w);
      wr(5'h0f, 8'h21);
      rd(1, w);
      chk("kept ptr", 16'h0021, w);
      host.start();
      host.byte_w(8'h72, ak);
      host.byte_w(8'h33, ak);
      host.stop();
      chk("data only", 16'h0033, 16'(cfg.gain));
      wr(5'h10, 8'h5a);
      rd(1, w);
      chk("unmapped", 16'h0000, w);
      wr(5'h0d, 8'h02);
      wr(5'h03, 8'hfe);
      host.wt(4);
      chk("long wait", 16'h0018, 16'(span));
      for (int i = 0; i < 4; i++) begin
         head(8'he0 | (i == 3 ? 8'h00 : 8'(5 + i)));
         host.stop();
         chk("prox clr", 16'(i < 2 ? 1 : 2), 16'(n_prox));
         chk("light clr", 16'(i < 1 ? 0 : i < 2 ? 1 : 2), 16'(n_light));
      end
      close_out();
   end
endmodule
